// [logic/i2c_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface i2c_link_if;
   logic scl_m_o;
   logic scl_m_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   wire  scl = ~(scl_m_oe & ~scl_m_o);
   wire  sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
   modport master (output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe,
                   input scl, input sda);
   modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface
`default_nettype wire

// [logic/i2c_nv_master.sv]
`timescale 1ns/1ns
`default_nettype none
module i2c_nv_master #(
   parameter int HALF_STD  = nvmux_pkg::SCL_HALF_STD,
   parameter int HALF_FAST = nvmux_pkg::SCL_HALF_FAST
) (
   input  wire logic       ref_clk_i,
   input  wire logic       rstn_i,
   i2c_link_if.master      bus,
   input  wire logic       go_i,
   input  wire logic       read_i,
   input  wire logic       fast_i,
   input  wire logic [7:0] wdata_i,
   output logic            busy_o,
   output logic            done_o,
   output logic            nack_o,
   output logic [7:0]      rdata_o
);
   import nvmux_pkg::*;

   typedef enum logic [3:0] {
      M_IDLE = 4'h1, M_START = 4'h2, M_BITS = 4'h4, M_STOP = 4'h8
   } mst_t;

   mst_t       st_r;
   logic [1:0] sda_s_r;
   logic [7:0] cnt_r;
   logic [1:0] ph_r;
   logic [4:0] bit_r;
   logic [17:0] tx_r;
   logic       scl_r, sda_r, rd_r, fast_r, busy_r, done_r, nack_r;
   logic [7:0] rx_r;

   always_ff @(posedge ref_clk_i) sda_s_r <= {sda_s_r[0], bus.sda};

   wire [7:0] half = fast_r ? 8'(HALF_FAST) : 8'(HALF_STD);
   wire       tick = (cnt_r == 8'h0);

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         st_r <= M_IDLE; cnt_r <= 8'h0; ph_r <= 2'd0; bit_r <= 5'd0;
         tx_r <= 18'h0; scl_r <= 1'b1; sda_r <= 1'b1; rd_r <= 1'b0;
         fast_r <= 1'b0; busy_r <= 1'b0; done_r <= 1'b0; nack_r <= 1'b0;
         rx_r <= 8'h00;
      end else begin
         done_r <= 1'b0;
         cnt_r  <= tick ? half : cnt_r - 8'h1;
         case (st_r)
            M_IDLE: if (go_i) begin
               rd_r   <= read_i;
               fast_r <= fast_i;
               // address, ack slot, data byte, ack slot (master acks read with nack)
               tx_r   <= {DEV_ADDR, read_i, 1'b1, read_i ? 8'hFF : wdata_i, 1'b1};
               busy_r <= 1'b1;
               nack_r <= 1'b0;
               st_r   <= M_START;
               ph_r   <= 2'd0;
            end
            M_START: if (tick) begin
               sda_r <= 1'b0;
               st_r  <= M_BITS;
               bit_r <= 5'd0;
            end
            M_BITS: if (tick) begin
               ph_r <= ph_r + 2'd1;
               case (ph_r)
                  2'd0: begin scl_r <= 1'b0; end
                  2'd1: begin sda_r <= tx_r[17]; end
                  2'd2: begin scl_r <= 1'b1; end
                  default: begin
                     if (bit_r == 5'd8 && sda_s_r[1]) nack_r <= 1'b1;
                     if (rd_r && bit_r > 5'd8 && bit_r < 5'd17)
                        rx_r <= {rx_r[6:0], sda_s_r[1]};
                     tx_r  <= {tx_r[16:0], 1'b1};
                     bit_r <= bit_r + 5'd1;
                     if (bit_r == 5'd17) st_r <= M_STOP;
                  end
               endcase
            end
            M_STOP: if (tick) begin
               ph_r <= ph_r + 2'd1;
               case (ph_r)
                  2'd0: scl_r <= 1'b0;
                  2'd1: sda_r <= 1'b0;
                  2'd2: scl_r <= 1'b1;
                  default: begin
                     sda_r  <= 1'b1;
                     busy_r <= 1'b0;
                     done_r <= 1'b1;
                     st_r   <= M_IDLE;
                  end
               endcase
            end
            default: st_r <= M_IDLE;
         endcase
      end
   end

   assign bus.scl_m_o  = 1'b0;
   assign bus.scl_m_oe = ~scl_r;
   assign bus.sda_m_o  = 1'b0;
   assign bus.sda_m_oe = ~sda_r;
   assign busy_o  = busy_r;
   assign done_o  = done_r;
   assign nack_o  = nack_r;
   assign rdata_o = rx_r;
endmodule
`default_nettype wire

// [logic/nvmux_dev.sv]
`timescale 1ns/1ns
`default_nettype none
module nvmux_dev #(
   parameter int COMMIT_CYCLES = nvmux_pkg::COMMIT_CYC
) (
   input  wire logic       ref_clk_i,
   input  wire logic       rstn_i,
   i2c_link_if.slave       bus,
   input  wire logic       write_guard_i,
   input  wire logic       override_i,
   input  wire logic       source_select_in_i,
   input  wire logic [3:0] parallel_in_i,
   output logic [3:0]      selected_out_o,
   output logic            separate_out_o,
   output logic            commit_busy_o
);
   import nvmux_pkg::*;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01, S_ADDR = 6'h02, S_AACK = 6'h04,
      S_RDAT = 6'h08, S_WDAT = 6'h10, S_DACK = 6'h20
   } st_t;

   logic [1:0] scl_s_r, sda_s_r, guard_s_r, ovr_s_r, sel_s_r;
   logic [3:0] pin_s1_r, pin_s2_r;
   logic       scl_d_r, sda_d_r, sel_d_r;
   always_ff @(posedge ref_clk_i) begin
      scl_s_r   <= {scl_s_r[0], bus.scl};
      sda_s_r   <= {sda_s_r[0], bus.sda};
      guard_s_r <= {guard_s_r[0], write_guard_i};
      ovr_s_r   <= {ovr_s_r[0], override_i};
      sel_s_r   <= {sel_s_r[0], source_select_in_i};
      pin_s1_r  <= parallel_in_i;
      pin_s2_r  <= pin_s1_r;
      scl_d_r   <= scl_s_r[1];
      sda_d_r   <= sda_s_r[1];
      sel_d_r   <= sel_s_r[1];
   end

   wire scl_q     = scl_s_r[1];
   wire sda_q     = sda_s_r[1];
   wire scl_rise  = scl_q & ~scl_d_r;
   wire scl_fall  = ~scl_q & scl_d_r;
   wire start_det = scl_q & scl_d_r & sda_d_r & ~sda_q;
   wire stop_det  = scl_q & scl_d_r & ~sda_d_r & sda_q;

   st_t         st_r;
   logic [7:0]  sh_r;
   logic [3:0]  bit_r;
   logic        rd_r, got_data_r, pend_r, sda_oe_r, ack_seen_r;
   logic [4:0]  cfg_r, pend_val_r;
   logic [31:0] busy_cnt_r;
   logic        busy_r, sep_hold_r;
   logic [3:0]  sel_out_r;

   wire byte_done  = (bit_r == 4'd8);
   wire addr_match = (sh_r[7:1] == DEV_ADDR) && (sh_r != GEN_CALL) && !busy_r;
   wire data_valid = (sh_r[7:5] == 3'b000);
   wire commit_go  = stop_det & pend_r & !busy_r;

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         st_r       <= S_IDLE;
         sh_r       <= 8'h00;
         bit_r      <= 4'h0;
         rd_r       <= 1'b0;
         got_data_r <= 1'b0;
         pend_r     <= 1'b0;
         pend_val_r <= CFG_RESET;
         sda_oe_r   <= 1'b0;
         ack_seen_r <= 1'b0;
      end else if (start_det) begin
         st_r       <= S_ADDR;
         bit_r      <= 4'h0;
         sda_oe_r   <= 1'b0;
         got_data_r <= 1'b0;
         pend_r     <= 1'b0;
      end else if (stop_det) begin
         st_r     <= S_IDLE;  // partial byte simply dropped
         sda_oe_r <= 1'b0;
         pend_r   <= 1'b0;
      end else begin
         case (st_r)
            S_IDLE: sda_oe_r <= 1'b0;
            S_ADDR: begin
               if (scl_rise) begin
                  sh_r  <= {sh_r[6:0], sda_q};
                  bit_r <= bit_r + 4'd1;
               end else if (scl_fall && byte_done) begin
                  if (addr_match) begin
                     sda_oe_r <= 1'b1;
                     rd_r     <= sh_r[0];
                     st_r     <= S_AACK;
                  end else begin
                     st_r <= S_IDLE;
                  end
               end
            end
            S_AACK: if (scl_fall) begin
               bit_r <= 4'h0;
               if (rd_r) begin
                  // data MSB is always zero, so the ack pull simply carries on
                  sda_oe_r <= 1'b1;
                  sh_r     <= {3'b000, cfg_r};
                  st_r     <= S_RDAT;
               end else begin
                  sda_oe_r <= 1'b0;
                  st_r     <= S_WDAT;
               end
            end
            S_RDAT: begin
               sda_oe_r <= ~sh_r[7] & ~byte_done;
               if (scl_fall) begin
                  if (byte_done) begin
                     sda_oe_r <= 1'b0;
                     st_r     <= S_IDLE;
                  end else begin
                     sh_r  <= {sh_r[6:0], 1'b0};
                     bit_r <= bit_r + 4'd1;
                  end
               end
            end
            S_WDAT: begin
               if (scl_rise) begin
                  sh_r  <= {sh_r[6:0], sda_q};
                  bit_r <= bit_r + 4'd1;
               end else if (scl_fall && byte_done) begin
                  sda_oe_r   <= ~got_data_r;
                  ack_seen_r <= ~got_data_r & data_valid;
                  if (!got_data_r) pend_val_r <= sh_r[4:0];
                  got_data_r <= 1'b1;
                  st_r       <= S_DACK;
               end
            end
            S_DACK: if (scl_fall) begin
               sda_oe_r <= 1'b0;
               bit_r    <= 4'h0;
               if (ack_seen_r && !guard_s_r[1]) pend_r <= 1'b1;
               ack_seen_r <= 1'b0;
               st_r       <= S_WDAT;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // commit window; register only lands as the window closes
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         cfg_r      <= CFG_RESET;
         busy_r     <= 1'b0;
         busy_cnt_r <= 32'h0;
      end else if (commit_go) begin
         busy_r     <= 1'b1;
         busy_cnt_r <= 32'(COMMIT_CYCLES);
      end else if (busy_r) begin
         busy_cnt_r <= busy_cnt_r - 32'h1;
         if (busy_cnt_r == 32'h1) begin
            busy_r <= 1'b0;
            cfg_r  <= pend_val_r;
         end
      end
   end

   wire sel_rise = sel_s_r[1] & ~sel_d_r;
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         sep_hold_r <= 1'b0;
         sel_out_r  <= 4'h0;
      end else begin
         if (!ovr_s_r[1]) sel_out_r <= 4'h0;
         else if (sel_s_r[1]) sel_out_r <= pin_s2_r;
         else sel_out_r <= cfg_r[3:0];
         if (!ovr_s_r[1] && !sel_s_r[1]) sep_hold_r <= 1'b0;
         else if (sel_s_r[1] && !sel_rise) sep_hold_r <= sep_hold_r;
         else if (!sel_s_r[1] && !busy_r) sep_hold_r <= cfg_r[SEP_BIT];
      end
   end

   assign selected_out_o = sel_out_r;
   assign separate_out_o = sep_hold_r;
   assign commit_busy_o  = busy_r;
   assign bus.sda_s_o    = 1'b0;
   assign bus.sda_s_oe   = sda_oe_r;
endmodule
`default_nettype wire

// [logic/nvmux_pkg.sv]
// Behaviour
// - start is SDA fall while SCL high
// - address MSB first, 1001110 plus direction
// - general call address gets no answer
// - own address acknowledged low on ninth clock
// - read returns stored register contents
// - valid data has bits 7..5 zero
// - first data byte, if valid, committed at stop only
// - invalid data acknowledged, never committed
// - bytes after first data byte ignored
// - stop is SDA rise while SCL high
// - write guard sampled at ack fall
// - partial byte before stop never written
// - no address ack during commit time
// - guard high at data ack fall blocks the register update
// - override low forces selected output low, separate output only while select low
// - select chooses register or parallel inputs
// - separate output held while select high
// - separate output frozen during commit, unless override low with select low forces it low
// - register starts all zeros
// - standard and fast bus rates work
package nvmux_pkg;
   localparam logic [6:0] DEV_ADDR      = 7'h4E;
   localparam logic [7:0] GEN_CALL      = 8'h00;
   localparam int         CFG_W         = 5;
   localparam logic [4:0] CFG_RESET     = 5'h00;
   localparam int         SEP_BIT       = 4;
   localparam int         COMMIT_MS     = 10;
   localparam int         CLK_HZ        = 10_000_000;
   localparam int         COMMIT_CYC    = (COMMIT_MS * (CLK_HZ / 1000));
   localparam int         SCL_HALF_STD  = 50;
   localparam int         SCL_HALF_FAST = 13;
endpackage

// [sim/i2c_nv_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module i2c_nv_asserts
   import nvmux_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_s_oe_i
);
   logic       scl_r;
   logic       sda_r;
   logic       rw_r;
   logic [5:0] bit_cnt_r;
   logic [7:0] shift_r;
   wire        scl_rise = scl_i & ~scl_r;
   wire        start    = scl_i & scl_r & sda_r & ~sda_i;
   wire        stop     = scl_i & scl_r & ~sda_r & sda_i;
   // count saturates so long write tails stay out of the ack window
   always_ff @(posedge ref_clk_i) begin
      scl_r <= scl_i;
      sda_r <= sda_i;
      if (!rstn_i) bit_cnt_r <= 6'h3F;
      else if (start) bit_cnt_r <= 6'h00;
      else if (scl_rise && bit_cnt_r != 6'h3F) bit_cnt_r <= bit_cnt_r + 6'h01;
      if (scl_rise) shift_r <= {shift_r[6:0], sda_i};
      if (!rstn_i) rw_r <= 1'b0;
      else if (scl_rise && bit_cnt_r == 6'h07) rw_r <= sda_i;
   end
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);
   a_slave_moves_low: assert property ($changed(sda_s_oe_i) |-> !scl_i)
      else $error("slave changed SDA while SCL high");
   a_ack_holds: assert property ($rose(scl_i) && sda_s_oe_i |-> sda_s_oe_i [*8])
      else $error("slave released SDA during SCL high");
   a_ack_own_addr: assert property ($rose(sda_s_oe_i) && bit_cnt_r == 6'h08
      |-> shift_r[7:1] == DEV_ADDR)
      else $error("address ack for foreign address");
   a_drive_window: assert property ($rose(sda_s_oe_i)
      |-> bit_cnt_r inside {[6'h08:6'h11]})
      else $error("slave drove SDA outside its slots");
   a_no_extra_ack: assert property (sda_s_oe_i |-> bit_cnt_r <= 6'h12)
      else $error("slave answered an extra byte");
   a_read_release: assert property (rw_r && bit_cnt_r == 6'h12
      |-> !sda_s_oe_i)
      else $error("slave held SDA in master ack slot");
   a_start_quiet: assert property (start |-> !sda_s_oe_i [*8])
      else $error("slave drove SDA after start");
   a_stop_quiet: assert property (stop |-> !sda_s_oe_i [*8])
      else $error("slave drove SDA after stop");
endmodule
`default_nettype wire

// [sim/i2c_nv_register_mux_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; $display("ERROR %0t got %h want %h", $time, a, e); end end
module i2c_nv_register_mux_tb;
   import nvmux_pkg::*;
   // long enough that a retry lands inside the commit window
   localparam int COMMIT = 2000;
   logic       ref_clk_i   = 1'b0;
   logic       rstn_i      = 1'b0;
   logic       go_i        = 1'b0;
   logic       read_i      = 1'b0;
   logic       fast_i      = 1'b0;
   logic [7:0] wdata_i     = 8'h00;
   logic       guard       = 1'b0;
   logic       ovr         = 1'b1;
   logic       sel         = 1'b0;
   logic [3:0] par         = 4'h0;
   logic [3:0] sel_out;
   logic       sep_out;
   logic       busy_c;
   logic       busy_o;
   logic       done_o;
   logic       nack_o;
   logic [7:0] rdata_o;
   int         error_cnt   = 0;
   int         check_count = 0;
   i2c_link_if link ();
   always #50 ref_clk_i = ~ref_clk_i;
   nvmux_dev #(.COMMIT_CYCLES(COMMIT)) nvmux_dev_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
      .bus(link.slave), .write_guard_i(guard), .override_i(ovr), .source_select_in_i(sel),
      .parallel_in_i(par), .selected_out_o(sel_out), .separate_out_o(sep_out),
      .commit_busy_o(busy_c));
   i2c_nv_master i2c_nv_master_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus(link.master),
      .go_i(go_i), .read_i(read_i), .fast_i(fast_i), .wdata_i(wdata_i), .busy_o(busy_o),
      .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
   i2c_nv_asserts i2c_nv_asserts_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .scl_i(link.scl),
      .sda_i(link.sda), .sda_s_oe_i(link.sda_s_oe));
   task automatic results();
      if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #5;
   endtask
   task automatic xfer(input logic rd, input logic fs, input logic [7:0] wd);
      int n;
      read_i = rd;
      fast_i = fs;
      wdata_i = wd;
      go_i = 1'b1;
      tick(1);
      go_i = 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 20000) begin
         tick(1);
         n++;
      end
      if (n == 20000) begin
         error_cnt++;
         results();
      end
   endtask
   task automatic wait_commit();
      int n;
      n = 0;
      while (busy_c !== 1'b0 && n < 5000) begin
         tick(1);
         n++;
      end
      if (n == 5000) begin
         error_cnt++;
         results();
      end
      tick(2);
   endtask
   initial begin
      tick(20);
      rstn_i = 1'b1;
      tick(2);
      `CHK(sel_out, 4'h0)
      `CHK(sep_out, 1'b0)
      xfer(1'b1, 1'b0, 8'h00);
      `CHK(nack_o, 1'b0)
      `CHK(rdata_o, 8'h00)
      `CHK(busy_o, 1'b0)
      xfer(1'b0, 1'b0, 8'h15);
      `CHK(nack_o, 1'b0)
      tick(4);
      `CHK(busy_c, 1'b1)
      `CHK(sep_out, 1'b0)
      xfer(1'b1, 1'b1, 8'h00);
      `CHK(nack_o, 1'b1)
      `CHK(sep_out, 1'b0)
      wait_commit();
      `CHK(sel_out, 4'h5)
      `CHK(sep_out, 1'b1)
      xfer(1'b0, 1'b1, 8'hE3);
      `CHK(nack_o, 1'b0)
      tick(4);
      `CHK(busy_c, 1'b0)
      guard = 1'b1;
      xfer(1'b0, 1'b1, 8'h0A);
      `CHK(nack_o, 1'b0)
      tick(4);
      `CHK(busy_c, 1'b0)
      guard = 1'b0;
      xfer(1'b1, 1'b1, 8'h00);
      `CHK(rdata_o, 8'h15)
      ovr = 1'b0;
      tick(3);
      `CHK(sel_out, 4'h0)
      `CHK(sep_out, 1'b0)
      ovr = 1'b1;
      par = 4'hA;
      tick(3);
      sel = 1'b1;
      tick(3);
      `CHK(sel_out, 4'hA)
      `CHK(sep_out, 1'b1)
      xfer(1'b0, 1'b1, 8'h00);
      tick(4);
      `CHK(busy_c, 1'b1)
      wait_commit();
      `CHK(sep_out, 1'b1)
      sel = 1'b0;
      tick(3);
      `CHK(sep_out, 1'b0)
      `CHK(sel_out, 4'h0)
      results();
   end
endmodule
`default_nettype wire
